// file: shared/ccs_pkg.sv
// Constants and carrier types for the capacitance calibration sequencer.
// Assumes a byte-wide register port decoded by an external serial slave.
package ccs_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] RUN_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] FUNCTION_CONFIG_1_ADDR = 8'h01;
  localparam logic [7:0] FUNCTION_CONFIG_2_ADDR = 8'h02;
  localparam logic [7:0] IRQ_STATUS_2_ADDR = 8'h06;
  localparam logic [7:0] SENSOR0_STATIC_OFFSET_ADDR = 8'h62;
  localparam logic [7:0] SENSOR13_STATIC_OFFSET_ADDR = 8'h6f;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int RUN_BIT = 0;
  localparam int IRQ_FLOAT_BIT = 5;
  localparam int CAL_MODE_BIT = 7;
  localparam int IRQ_DONE_BIT = 0;
  localparam logic [7:0] RUN_CONTROL_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] OFFSET_RST = 8'h00;

  // ----------------------------------------
  // Sensor scan
  // ----------------------------------------
  localparam int NUM_INPUTS = 14;
  localparam int IDX_W = 4;
  localparam logic [3:0] LAST_INPUT = 4'hd;
  // Last count of a slot; one input takes seventeen cycles and the front end gives its result at the end
  localparam logic [7:0] SLOT_CYCLES = 8'h10;
  // Last gap count; 34 idle cycles lie between two scans, the window in which the host may read
  localparam logic [7:0] GAP_CYCLES = 8'h20;

  typedef enum logic [3:0] {
    CCS_IDLE = 4'b0001,
    CCS_SCAN = 4'b0010,
    CCS_DONE = 4'b0100,
    CCS_GAP  = 4'b1000
  } ccs_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccs_reg_req_t;

endpackage : ccs_pkg

// file: rtl/ccs_offset_mem.sv
// Fourteen-entry static offset store with registered read data.
// Assumes one writer port shared by host writes and calibration stores.
`timescale 1ns/1ps
module ccs_offset_mem (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write port
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // Read port
  input wire logic [3:0] raddr_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem_q [ccs_pkg::NUM_INPUTS];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  for (genvar g = 0; g < ccs_pkg::NUM_INPUTS; g++) begin : g_ent
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        mem_q[g] <= ccs_pkg::OFFSET_RST;
      end else if (we_i && waddr_i == 4'(g)) begin
        mem_q[g] <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (raddr_i <= ccs_pkg::LAST_INPUT) begin
      rdata_o <= mem_q[raddr_i];
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule : ccs_offset_mem

// file: rtl/ccs_sequencer.sv
// Run/standby sequencing, static offset calibration and interrupt pin control.
// Assumes a serial slave turns bus transfers into single-cycle read/write
// strobes and an analog front end returns one sample per input slot.
`timescale 1ns/1ps

module ccs_sequencer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port from the serial slave
  input wire ccs_pkg::ccs_reg_req_t req_i,
  output logic [7:0] rdata_o,
  // Analog front end
  input wire logic [7:0] sample_i,
  output logic [3:0] sense_sel_o,
  output logic sample_valid_o,
  output logic [15:0] result_o,
  // Interrupt pin
  output logic irq_pin_o,
  output logic irq_pin_oe_n_o,
  // Sensor drive line
  output logic sensor_drive_line_o,
  output logic sensor_drive_line_oe_n_o,
  // Status
  output logic measuring_o
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] run_control_q;
  logic [7:0] function_config_1_q;
  logic [7:0] function_config_2_q;
  logic irq_pend_q;
  ccs_pkg::ccs_state_t state_q, state_d;
  logic [3:0] idx_q;
  logic [7:0] cnt_q;
  logic drive_q;
  logic [7:0] rdata_q;
  logic rd_mem_q;
  logic [3:0] rd_idx_q;
  logic [15:0] result_q;
  logic sample_valid_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic wr_ctl = req_i.wr && req_i.addr == ccs_pkg::RUN_CONTROL_ADDR;
  wire logic wr_cfg1 = req_i.wr && req_i.addr == ccs_pkg::FUNCTION_CONFIG_1_ADDR;
  wire logic wr_cfg2 = req_i.wr && req_i.addr == ccs_pkg::FUNCTION_CONFIG_2_ADDR;
  wire logic rd_stat = req_i.rd && req_i.addr == ccs_pkg::IRQ_STATUS_2_ADDR;
  wire logic in_ofs = req_i.addr >= ccs_pkg::SENSOR0_STATIC_OFFSET_ADDR &&
                      req_i.addr <= ccs_pkg::SENSOR13_STATIC_OFFSET_ADDR;
  wire logic [7:0] ofs_rel = req_i.addr - ccs_pkg::SENSOR0_STATIC_OFFSET_ADDR;
  wire logic [3:0] ofs_idx = ofs_rel[3:0];
  wire logic run = run_control_q[ccs_pkg::RUN_BIT];
  // Mode is read unregistered at each slot end so a mode change applies from the slot in progress
  wire logic cal_mode = function_config_1_q[ccs_pkg::CAL_MODE_BIT];
  wire logic slot_end = state_q == ccs_pkg::CCS_SCAN && cnt_q == ccs_pkg::SLOT_CYCLES;
  wire logic cal_store = slot_end && cal_mode;
  wire logic scan_done = state_q == ccs_pkg::CCS_DONE;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_control_q <= ccs_pkg::RUN_CONTROL_RST;
      function_config_1_q <= ccs_pkg::CONFIG_RST;
      function_config_2_q <= ccs_pkg::CONFIG_RST;
    end else begin
      // Float and run land in one write, so a restart floats the pin only if bit 5 is set with it
      if (wr_ctl) run_control_q <= req_i.wdata;
      if (wr_cfg1) function_config_1_q <= req_i.wdata;
      if (wr_cfg2) function_config_2_q <= req_i.wdata;
    end
  end

  // ----------------------------------------
  // Scan sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ccs_pkg::CCS_IDLE: if (run) state_d = ccs_pkg::CCS_SCAN;
      ccs_pkg::CCS_SCAN: begin
        if (slot_end && idx_q == ccs_pkg::LAST_INPUT) state_d = ccs_pkg::CCS_DONE;
      end
      ccs_pkg::CCS_DONE: state_d = ccs_pkg::CCS_GAP;
      ccs_pkg::CCS_GAP: begin
        // Standby is entered only from the gap, so a scan always completes
        if (!run) state_d = ccs_pkg::CCS_IDLE;
        else if (cnt_q == ccs_pkg::GAP_CYCLES) state_d = ccs_pkg::CCS_SCAN;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ccs_pkg::CCS_IDLE;
      idx_q <= 4'h0;
      cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_d != state_q || slot_end) cnt_q <= 8'h00;
      else cnt_q <= cnt_q + 8'h01;
      // Cleared as the scan ends, so the select never shows a fifteenth input
      if (state_d != ccs_pkg::CCS_SCAN) idx_q <= 4'h0;
      else if (slot_end) idx_q <= idx_q + 4'h1;
    end
  end

  // ----------------------------------------
  // Interrupt and drive pins
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_pend_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      // A completing scan wins over the acknowledging read
      if (scan_done) irq_pend_q <= 1'b1;
      else if (rd_stat) irq_pend_q <= 1'b0;
      drive_q <= state_q == ccs_pkg::CCS_SCAN && cnt_q < (ccs_pkg::SLOT_CYCLES >> 1);
    end
  end

  // Driven level is always defined low or high while not floated
  assign irq_pin_o = irq_pend_q;
  assign irq_pin_oe_n_o = run_control_q[ccs_pkg::IRQ_FLOAT_BIT];
  assign sensor_drive_line_o = drive_q;
  assign sensor_drive_line_oe_n_o = state_q != ccs_pkg::CCS_SCAN;
  assign measuring_o = state_q == ccs_pkg::CCS_SCAN;
  assign sense_sel_o = idx_q;

  // ----------------------------------------
  // Offset store and results
  // ----------------------------------------
  wire logic mem_we = cal_store || (req_i.wr && in_ofs && !cal_store);
  wire logic [3:0] mem_waddr = cal_store ? idx_q : ofs_idx;
  wire logic [7:0] mem_wdata = cal_store ? sample_i : req_i.wdata;
  logic [7:0] mem_rdata;
  // Read address held after the read so offset read data stands until the next read
  wire logic [3:0] mem_raddr = req_i.rd ? ofs_idx : rd_idx_q;

  ccs_offset_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_q <= 16'h0000;
      sample_valid_q <= 1'b0;
    end else begin
      sample_valid_q <= slot_end && !cal_mode;
      // Raw sample; offsets are stored here but not applied to the result
      if (slot_end && !cal_mode) result_q <= {idx_q, 4'h0, sample_i};
    end
  end

  assign result_o = result_q;
  assign sample_valid_o = sample_valid_q;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire logic [7:0] stat_val = {7'h00, irq_pend_q};
  wire logic [7:0] rd_mux = (req_i.addr == ccs_pkg::RUN_CONTROL_ADDR) ? run_control_q :
                            (req_i.addr == ccs_pkg::FUNCTION_CONFIG_1_ADDR) ? function_config_1_q :
                            (req_i.addr == ccs_pkg::FUNCTION_CONFIG_2_ADDR) ? function_config_2_q :
                            (req_i.addr == ccs_pkg::IRQ_STATUS_2_ADDR) ? stat_val : 8'h00;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
      rd_mem_q <= 1'b0;
      rd_idx_q <= 4'h0;
    end else if (req_i.rd) begin
      rdata_q <= rd_mux;
      rd_mem_q <= in_ofs;
      rd_idx_q <= ofs_idx;
    end
  end

  assign rdata_o = rd_mem_q ? mem_rdata : rdata_q;

endmodule : ccs_sequencer

// file: test/ccs_sequencer_chk.sv
// Port-level checks for the calibration sequencer.
// Assumes one clock and the asynchronous active-high reset of the design.
`timescale 1ns/1ps
module ccs_sequencer_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire ccs_pkg::ccs_reg_req_t req_i,
  input wire logic [3:0] sense_sel_o,
  input wire logic sample_valid_o,
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe_n_o,
  input wire logic sensor_drive_line_oe_n_o,
  input wire logic measuring_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [8:0] scan_q;
  logic [8:0] scan_d;
  logic run_q;
  wire ctl_wr = req_i.wr && req_i.addr == 8'h00;
  wire stat_rd = req_i.rd && req_i.addr == 8'h06;
  // Fourteen slots of seventeen cycles make one scan
  assign scan_d = measuring_o ? scan_q + 9'h001 : 9'h000;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) scan_q <= 9'h000;
    else scan_q <= scan_d;
  end
  // Last run bit written, so a repeated run write in the gap is not taken as a start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) run_q <= 1'b0;
    else if (ctl_wr) run_q <= req_i.wdata[0];
  end
  property p_float_set; ctl_wr && req_i.wdata[5] |=> irq_pin_oe_n_o; endproperty
  a_float_set: assert property (p_float_set) else $error("pin not floated");
  property p_float_clr; ctl_wr && !req_i.wdata[5] |=> !irq_pin_oe_n_o; endproperty
  a_float_clr: assert property (p_float_clr) else $error("pin not driven");
  property p_start;
    ctl_wr && req_i.wdata == 8'h01 && !measuring_o && !run_q |=> ##[0:2] measuring_o;
  endproperty
  a_start: assert property (p_start) else $error("scan did not start");
  property p_done; $fell(measuring_o) |=> irq_pin_o; endproperty
  a_done: assert property (p_done) else $error("no irq after scan");
  property p_clear; stat_rd && !$fell(measuring_o) |=> !irq_pin_o; endproperty
  a_clear: assert property (p_clear) else $error("irq not cleared");
  property p_drive; sensor_drive_line_oe_n_o == !measuring_o; endproperty
  a_drive: assert property (p_drive) else $error("drive line enable wrong");
  property p_scan_len; $fell(measuring_o) |-> scan_q == 9'h0ee; endproperty
  a_scan_len: assert property (p_scan_len) else $error("scan length wrong");
  property p_sel; measuring_o |-> sense_sel_o <= 4'hd; endproperty
  a_sel: assert property (p_sel) else $error("input index out of range");
  property p_idle_sel; !measuring_o |-> sense_sel_o == 4'h0; endproperty
  a_idle_sel: assert property (p_idle_sel) else $error("input selected outside scan");
  property p_valid; sample_valid_o |-> $past(measuring_o); endproperty
  a_valid: assert property (p_valid) else $error("sample outside scan");
endmodule : ccs_sequencer_chk

bind ccs_sequencer ccs_sequencer_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
  .sense_sel_o(sense_sel_o), .sample_valid_o(sample_valid_o), .irq_pin_o(irq_pin_o),
  .irq_pin_oe_n_o(irq_pin_oe_n_o), .sensor_drive_line_oe_n_o(sensor_drive_line_oe_n_o),
  .measuring_o(measuring_o));

// file: test/ccs_fe_model.sv
// Behavioural front end returning a sample tied to the selected input.
// Assumes the sequencer samples it at slot end while measuring.
`timescale 1ns/1ps
module ccs_fe_model (
  // Clock
  input wire logic clk_i,
  // From the sequencer
  input wire logic [3:0] sense_sel_i,
  input wire logic measuring_i,
  // To the sequencer
  output logic [7:0] sample_o
);
  initial sample_o = 8'h00;
  // Outside a scan the value toggles so stale data never looks valid
  always @(posedge clk_i) sample_o <= measuring_i ? {4'h5, sense_sel_i} : ~sample_o;
endmodule : ccs_fe_model

// file: test/tb.sv
// Self-checking bench: reset values, calibration, repeated scans, pin float.
// Assumes the front-end model and the bound checker.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  ccs_pkg::ccs_reg_req_t req_i = '0;
  logic [7:0] rdata_o, sample_i;
  logic [3:0] sense_sel_o;
  logic sample_valid_o, irq_pin_o, irq_pin_oe_n_o, drv_o, drv_oe_n_o, measuring_o;
  logic [15:0] result_o;
  int mismatches = 0;
  int checks = 0;
  int pulses = 0;
  int n;
  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) if (sample_valid_o === 1'b1) pulses++;
  ccs_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .sample_i(sample_i), .sense_sel_o(sense_sel_o), .sample_valid_o(sample_valid_o),
    .result_o(result_o), .irq_pin_o(irq_pin_o), .irq_pin_oe_n_o(irq_pin_oe_n_o),
    .sensor_drive_line_o(drv_o), .sensor_drive_line_oe_n_o(drv_oe_n_o),
    .measuring_o(measuring_o));
  ccs_fe_model u_fe (.clk_i(clk_i), .sense_sel_i(sense_sel_o), .measuring_i(measuring_o),
    .sample_o(sample_i));
  // ----------------------------------------
  // Register access and waits
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_i = {1'b1, 1'b0, a, d};
    @(negedge clk_i);
    req_i = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    req_i = {1'b0, 1'b1, a, 8'h00};
    @(negedge clk_i);
    req_i = '0;
    `CHK(rdata_o, e)
  endtask : rd
  task automatic wait_irq();
    n = 0;
    while (irq_pin_o !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    `CHK(irq_pin_o, 1'b1)
  endtask : wait_irq
  // Stop in the gap, then acknowledge; reads stay out of the scan
  task automatic stop_ack();
    wr(8'h00, 8'h00);
    rd(8'h06, 8'h01);
    `CHK(irq_pin_o, 1'b0)
  endtask : stop_ack
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h62, 8'h00);
    rd(8'h10, 8'h00);
    `CHK(irq_pin_oe_n_o, 1'b0)
    $display("test reset done");
    wr(8'h01, 8'h80);
    wr(8'h02, 8'h5a);
    rd(8'h02, 8'h5a);
    wr(8'h00, 8'h01);
    wait_irq();
    stop_ack();
    for (int i = 0; i < 14; i++) rd(8'h62 + 8'(i), {4'h5, 4'(i)});
    $display("test calibration done");
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h20);
    `CHK(irq_pin_oe_n_o, 1'b1)
    pulses = 0;
    wr(8'h00, 8'h01);
    `CHK(irq_pin_oe_n_o, 1'b0)
    wait_irq();
    `CHK(pulses, 14)
    `CHK(result_o, 16'hd05d)
    rd(8'h06, 8'h01);
    n = 0;
    while (measuring_o !== 1'b1 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    `CHK(measuring_o, 1'b1)
    `CHK(drv_oe_n_o, 1'b0)
    @(negedge clk_i);
    `CHK(drv_o, 1'b1)
    wait_irq();
    stop_ack();
    repeat (60) @(negedge clk_i);
    `CHK(measuring_o, 1'b0)
    `CHK(drv_oe_n_o, 1'b1)
    $display("test normal done");
    wr(8'h62, 8'ha5);
    rd(8'h62, 8'ha5);
    $display("test offset write done");
    end_sim();
  end
endmodule : tb
